// file: shs_homing.sv
`timescale 1ns/1ns

// Function
// - Trigger ignored while interrupt positioning or multi-position runs.
// - Axis control mode 5 disables homing entirely.
// - Home is switch edge or Z pulse; zero is home plus offset.
// - Start only in position mode, with servo enabled before the trigger.
// - While homing, all other position references and retriggers are locked out.
// - Home attaining finds home, then moves the offset to zero.
// - Electrical homing is a relative move from the present position.
// - On completion absolute position monitor equals home offset.
// - Separate done flags for homing and electrical homing.
// - Trigger select: 0 off, 1/3/4 homing, 2/5 electrical.
// - Reference filters bypassed during homing.
// - Limit hit raises overtravel fault; select 0/1 stops by stop method.
// - Even mode codes 0..12 forward searches; 14,15,16 single-turn variants.
// - Undescribed modes mirror listed ones with reversed initial direction.
// - Switch off at start: fast forward, decelerate, slow reverse to fall.
// - After the reverse falling edge, slow forward to the home rising edge.
// - Switch on at start: slow reverse to fall, then slow forward.
// - Forward limit: select 2/3 auto reverse, 0/1 halt for new trigger.
// - After limit reversal: fast reverse to fall, decelerate, slow forward.
// - Stop on home rising edge is immediate.
module shs_homing #(
  parameter int CYC_PER_MS = shs_pkg::CYC_MS
) (
  // Clock, reset, enable
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        CLK_EN,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Drive status and sensors
  input  wire logic        SERVO_ON,
  input  wire logic        POS_MODE,
  input  wire logic        INTR_POS_BUSY,
  input  wire logic        MULTI_POS_BUSY,
  input  wire logic        HOMING_TRIGGER_INPUT,
  input  wire logic        HOME_SW,
  input  wire logic        Z_PULSE,
  input  wire logic        FWD_LIMIT,
  input  wire logic        REV_LIMIT,
  input  wire logic [31:0] POS_FB,
  input  wire logic        MOVE_DONE,
  // Motion commands
  output logic      [16:0] SPEED_CMD,
  output logic             DECEL_ACTIVE,
  output logic      [15:0] DECEL_TIME_MS,
  output logic             MOVE_START,
  output logic      [31:0] MOVE_DIST,
  output logic             STOP_REQ,
  output logic      [1:0]  STOP_METHOD,
  // Status
  output logic             REF_LOCK,
  output logic             FILTER_BYPASS,
  output logic             FWD_OT_FAULT,
  output logic             REV_OT_FAULT,
  output logic             HOMING_DONE,
  output logic             ELEC_HOMING_DONE,
  output logic      [31:0] ABS_POS
);

  typedef struct packed {
    shs_pkg::shs_state_t st;
    logic [3:0]          axis_mode;
    logic [3:0]          trig_sel;
    logic [4:0]          hmode;
    logic [1:0]          lim_ret;
    logic [1:0]          stop_sel;
    logic [15:0]         hi_spd;
    logic [15:0]         lo_spd;
    logic [15:0]         dec_ms;
    logic [31:0]         offset;
    logic [31:0]         adj;
    logic [31:0]         abs_pos;
    logic [16:0]         speed;
    logic [15:0]         cyc;
    logic [15:0]         ms;
    logic                dir;
    logic                lim_path;
    logic                lim_pend;
    logic                fault_fwd;
    logic                fault_rev;
    logic                stop_req;
    logic                done_h;
    logic                done_e;
    logic                move_start;
    logic [31:0]         move_dist;
    logic                trig_p;
    logic                son_p;
    logic                dec_p;
    logic                home_p;
    logic                a_wr;
    logic [7:0]          a_addr;
    logic [31:0]         rdata;
  } shs_regs_t;

  shs_regs_t q;
  shs_regs_t d;

  logic dec_sig;
  logic home_sig;
  logic dec_r;
  logic dec_f;
  logic home_r;
  logic lim_ahead;
  logic lim_any;
  logic blocked;
  logic go_home;
  logic go_elec;

  function automatic logic [16:0] vel(input logic [15:0] s, input logic neg);
    vel = neg ? (17'h0_0000 - {1'b0, s}) : {1'b0, s};
  endfunction : vel

  // Modes 2 and 3 use the Z pulse as deceleration point; the switch-home
  // modes 0 and 1 end on the switch, all others end on the Z pulse.
  always_comb begin
    dec_sig   = (q.hmode[4:1] == 4'h1) ? Z_PULSE : HOME_SW;
    home_sig  = (q.hmode[4:1] == 4'h0) ? HOME_SW : Z_PULSE;
    dec_r     = dec_sig & ~q.dec_p;
    dec_f     = ~dec_sig & q.dec_p;
    home_r    = home_sig & ~q.home_p;
    lim_ahead = q.dir ? REV_LIMIT : FWD_LIMIT;
    lim_any   = FWD_LIMIT | REV_LIMIT;
    blocked   = INTR_POS_BUSY | MULTI_POS_BUSY
              | (q.axis_mode == shs_pkg::AXIS_ENHANCED)
              | ~POS_MODE | ~SERVO_ON;
    go_home   = ~blocked & (((q.trig_sel == shs_pkg::TRG_PIN_HOME)
                             & HOMING_TRIGGER_INPUT & ~q.trig_p)
                          | (((q.trig_sel == shs_pkg::TRG_SON_A)
                             | (q.trig_sel == shs_pkg::TRG_SON_B))
                             & SERVO_ON & ~q.son_p));
    go_elec   = ~blocked & (((q.trig_sel == shs_pkg::TRG_PIN_ELEC)
                             & HOMING_TRIGGER_INPUT & ~q.trig_p)
                          | ((q.trig_sel == shs_pkg::TRG_SON_ELEC)
                             & SERVO_ON & ~q.son_p));
  end

  always_comb begin
    d            = q;
    d.move_start = 1'b0;
    d.stop_req   = 1'b0;
    d.trig_p     = HOMING_TRIGGER_INPUT;
    d.son_p      = SERVO_ON;
    d.dec_p      = dec_sig;
    d.home_p     = home_sig;
    d.abs_pos    = POS_FB + q.adj;

    case (q.st)
      shs_pkg::ST_IDLE: begin
        // Only idle accepts a start, so a retrigger while busy is dropped.
        if (go_home) begin
          d.done_h    = 1'b0;
          d.done_e    = 1'b0;
          d.fault_fwd = 1'b0;
          d.fault_rev = 1'b0;
          // Odd codes below 14 mirror the even ones.
          d.dir = (q.hmode < shs_pkg::MODE_ST_FWD) ? q.hmode[0]
                : (q.hmode == shs_pkg::MODE_ST_REV);
          if (q.lim_pend) begin
            d.lim_pend = 1'b0;
            d.st       = shs_pkg::ST_REV_HIGH;
            d.speed    = vel(q.hi_spd, ~d.dir);
          end else if (dec_sig) begin
            d.st    = shs_pkg::ST_REV_LOW;
            d.speed = vel(q.lo_spd, ~d.dir);
          end else begin
            d.st    = shs_pkg::ST_FWD_HIGH;
            d.speed = vel(q.hi_spd, d.dir);
          end
        end else if (go_elec) begin
          d.done_h     = 1'b0;
          d.done_e     = 1'b0;
          d.fault_fwd  = 1'b0;
          d.fault_rev  = 1'b0;
          d.lim_path   = 1'b1;
          d.st         = shs_pkg::ST_MOVE;
          d.move_start = 1'b1;
          d.move_dist  = q.offset - q.abs_pos;
        end
      end
      shs_pkg::ST_FWD_HIGH: begin
        if (!lim_any && dec_r) begin
          d.st       = shs_pkg::ST_DECEL;
          d.lim_path = 1'b0;
          d.speed    = vel(q.lo_spd, ~q.dir);
          d.cyc      = '0;
          d.ms       = '0;
        end
      end
      shs_pkg::ST_DECEL: begin
        if (q.ms == q.dec_ms) begin
          d.st = q.lim_path ? shs_pkg::ST_FWD_LOW : shs_pkg::ST_REV_LOW;
        end else if (q.cyc == 16'(CYC_PER_MS - 1)) begin
          d.cyc = '0;
          d.ms  = q.ms + 16'h0001;
        end else begin
          d.cyc = q.cyc + 16'h0001;
        end
      end
      shs_pkg::ST_REV_LOW: begin
        if (!lim_any && dec_f) begin
          d.st    = shs_pkg::ST_FWD_LOW;
          d.speed = vel(q.lo_spd, q.dir);
        end
      end
      shs_pkg::ST_FWD_LOW: begin
        if (!lim_any && home_r) begin
          d.st         = shs_pkg::ST_MOVE;
          d.speed      = '0;
          d.lim_path   = 1'b0;
          d.move_start = 1'b1;
          d.move_dist  = q.offset;
        end
      end
      shs_pkg::ST_REV_HIGH: begin
        if (!lim_any && dec_f) begin
          d.st       = shs_pkg::ST_DECEL;
          d.lim_path = 1'b1;
          d.speed    = vel(q.lo_spd, q.dir);
          d.cyc      = '0;
          d.ms       = '0;
        end
      end
      shs_pkg::ST_MOVE: begin
        if (MOVE_DONE) begin
          d.st      = shs_pkg::ST_IDLE;
          d.abs_pos = q.offset;
          d.adj     = q.offset - POS_FB;
          if (q.lim_path) begin
            d.done_e = 1'b1;
          end else begin
            d.done_h = 1'b1;
          end
        end
      end
      default: begin
        d.st = shs_pkg::ST_IDLE;
      end
    endcase

    // A limit hit during any active phase faults the axis.
    if (q.st != shs_pkg::ST_IDLE && lim_any) begin
      d.fault_fwd = q.fault_fwd | FWD_LIMIT;
      d.fault_rev = q.fault_rev | REV_LIMIT;
      if (q.st == shs_pkg::ST_FWD_HIGH && lim_ahead && q.lim_ret[1]) begin
        d.st    = shs_pkg::ST_REV_HIGH;
        d.speed = vel(q.hi_spd, ~q.dir);
      end else begin
        d.st       = shs_pkg::ST_IDLE;
        d.speed    = '0;
        d.stop_req = 1'b1;
        d.lim_pend = (q.st == shs_pkg::ST_FWD_HIGH) && lim_ahead;
      end
    end

    // Bus data phase: a write lands one cycle after its address phase.
    if (q.a_wr) begin
      case (q.a_addr)
        shs_pkg::OFS_CTRL: begin
          d.axis_mode = HWDATA[shs_pkg::CTRL_AXIS_LSB +: 4];
          d.trig_sel  = HWDATA[shs_pkg::CTRL_TRIG_LSB +: 4];
          d.hmode     = HWDATA[shs_pkg::CTRL_MODE_LSB +: 5];
          d.lim_ret   = HWDATA[shs_pkg::CTRL_LIMR_LSB +: 2];
          d.stop_sel  = HWDATA[shs_pkg::CTRL_STOP_LSB +: 2];
        end
        shs_pkg::OFS_HI_SPD: d.hi_spd = HWDATA[15:0];
        shs_pkg::OFS_LO_SPD: d.lo_spd = HWDATA[15:0];
        shs_pkg::OFS_DEC_MS: d.dec_ms = HWDATA[15:0];
        shs_pkg::OFS_OFFSET: d.offset = HWDATA;
        default: begin
        end
      endcase
    end

    // Read data is taken from the next state so a write is seen at once.
    d.a_wr = HSEL & HTRANS[1] & HREADY & HWRITE;
    if (HSEL & HTRANS[1] & HREADY) begin
      d.a_addr = HADDR[7:0];
      case (HADDR[7:0])
        shs_pkg::OFS_CTRL: d.rdata = {10'h000, d.stop_sel, 2'h0, d.lim_ret,
                                      3'h0, d.hmode, d.trig_sel, d.axis_mode};
        shs_pkg::OFS_HI_SPD: d.rdata = {16'h0000, d.hi_spd};
        shs_pkg::OFS_LO_SPD: d.rdata = {16'h0000, d.lo_spd};
        shs_pkg::OFS_DEC_MS: d.rdata = {16'h0000, d.dec_ms};
        shs_pkg::OFS_OFFSET: d.rdata = d.offset;
        shs_pkg::OFS_ABS:    d.rdata = d.abs_pos;
        shs_pkg::OFS_STATUS: d.rdata = {24'h00_0000, d.st, d.lim_pend,
                                        d.fault_rev, d.fault_fwd, d.done_e} |
                                       {27'h000_0000, d.done_h, 4'h0};
        default:             d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      q <= '0;
    end else if (CLK_EN) begin
      q <= d;
    end
  end

  // Holding ready low while frozen keeps the master from losing a phase.
  assign HREADYOUT        = CLK_EN;
  assign HRESP            = 1'b0;
  assign HRDATA           = q.rdata;
  assign SPEED_CMD        = q.speed;
  assign DECEL_ACTIVE     = (q.st == shs_pkg::ST_DECEL);
  assign DECEL_TIME_MS    = q.dec_ms;
  assign MOVE_START       = q.move_start;
  assign MOVE_DIST        = q.move_dist;
  assign STOP_REQ         = q.stop_req;
  assign STOP_METHOD      = q.stop_sel;
  assign REF_LOCK         = (q.st != shs_pkg::ST_IDLE);
  assign FILTER_BYPASS    = (q.st != shs_pkg::ST_IDLE);
  assign FWD_OT_FAULT     = q.fault_fwd;
  assign REV_OT_FAULT     = q.fault_rev;
  assign HOMING_DONE      = q.done_h;
  assign ELEC_HOMING_DONE = q.done_e;
  assign ABS_POS          = q.abs_pos;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET || !CLK_EN);

  sequence seq_sw_rise;
    q.st == shs_pkg::ST_FWD_HIGH && dec_r && !lim_any;
  endsequence

  sequence seq_home_hit;
    q.st == shs_pkg::ST_FWD_LOW && home_r && !lim_any;
  endsequence

  chk_ignore_busy: assert property (
    (q.st == shs_pkg::ST_IDLE && (INTR_POS_BUSY || MULTI_POS_BUSY)) |=> !REF_LOCK)
    else $error("start taken during another positioning");
  chk_axis_block: assert property (
    (q.st == shs_pkg::ST_IDLE && q.axis_mode == shs_pkg::AXIS_ENHANCED) |=> !REF_LOCK)
    else $error("start taken in enhanced axis mode");
  chk_start_cond: assert property (
    $rose(REF_LOCK) |-> $past(SERVO_ON) && $past(POS_MODE))
    else $error("start without servo on or position mode");
  chk_lock_done: assert property (
    $rose(HOMING_DONE) |-> $past(REF_LOCK) && !REF_LOCK)
    else $error("lockout not released at completion");
  chk_filter_off: assert property (
    FILTER_BYPASS == REF_LOCK)
    else $error("filter bypass differs from homing activity");
  chk_filter_start: assert property (
    (q.st == shs_pkg::ST_IDLE && (go_home || go_elec)) |=> FILTER_BYPASS && REF_LOCK)
    else $error("filter bypass not on at homing start");
  chk_offset_move: assert property (
    seq_home_hit |=> MOVE_START && MOVE_DIST == q.offset && SPEED_CMD == 17'h0_0000)
    else $error("home edge did not stop and start offset move");
  chk_elec_dist: assert property (
    (q.st == shs_pkg::ST_IDLE && go_elec && !go_home)
      |=> MOVE_START && MOVE_DIST == $past(q.offset) - $past(ABS_POS))
    else $error("electrical homing distance wrong");
  chk_abs_load: assert property (
    ($rose(HOMING_DONE) || $rose(ELEC_HOMING_DONE)) |-> ABS_POS == q.offset)
    else $error("absolute position not set to offset");
  chk_flag_clear: assert property (
    $rose(REF_LOCK) |-> !HOMING_DONE && !ELEC_HOMING_DONE)
    else $error("done flags not cleared on start");
  chk_mode0_decel: assert property (
    seq_sw_rise |=> DECEL_ACTIVE && SPEED_CMD == vel(q.lo_spd, ~q.dir))
    else $error("switch edge did not start deceleration");
  chk_rev_to_fwd: assert property (
    (q.st == shs_pkg::ST_REV_LOW && dec_f && !lim_any) |=> q.st == shs_pkg::ST_FWD_LOW)
    else $error("falling edge did not turn forward");
  chk_limit_fault: assert property (
    (REF_LOCK && FWD_LIMIT) |=> FWD_OT_FAULT)
    else $error("forward overtravel fault not raised");
  chk_limit_return: assert property (
    (q.st == shs_pkg::ST_FWD_HIGH && lim_ahead && q.lim_ret[1])
      |=> q.st == shs_pkg::ST_REV_HIGH)
    else $error("no automatic reverse at limit");

endmodule : shs_homing

// file: shs_pkg.sv
package shs_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_HI_SPD = 8'h04;
  localparam logic [7:0] OFS_LO_SPD = 8'h08;
  localparam logic [7:0] OFS_DEC_MS = 8'h0C;
  localparam logic [7:0] OFS_OFFSET = 8'h10;
  localparam logic [7:0] OFS_ABS    = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Field positions of the control register.
  localparam int CTRL_AXIS_LSB  = 0;
  localparam int CTRL_TRIG_LSB  = 4;
  localparam int CTRL_MODE_LSB  = 8;
  localparam int CTRL_LIMR_LSB  = 16;
  localparam int CTRL_STOP_LSB  = 20;

  // Encodings.
  localparam logic [3:0] AXIS_ENHANCED = 4'h5;
  localparam logic [3:0] TRG_PIN_HOME  = 4'h1;
  localparam logic [3:0] TRG_PIN_ELEC  = 4'h2;
  localparam logic [3:0] TRG_SON_A     = 4'h3;
  localparam logic [3:0] TRG_SON_B     = 4'h4;
  localparam logic [3:0] TRG_SON_ELEC  = 4'h5;
  localparam logic [4:0] MODE_ST_FWD   = 5'h0E;
  localparam logic [4:0] MODE_ST_REV   = 5'h0F;

  // Timing: one millisecond of the 20 MHz reference clock.
  localparam int MS_NS     = 1_000_000;
  localparam int CLK_NS    = 50;
  localparam int CYC_MS    = MS_NS / CLK_NS;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_FWD_HIGH = 4'h1,
    ST_DECEL    = 4'h2,
    ST_REV_LOW  = 4'h3,
    ST_FWD_LOW  = 4'h4,
    ST_REV_HIGH = 4'h5,
    ST_MOVE     = 4'h6
  } shs_state_t;

endpackage : shs_pkg

// file: shs_motor_model.sv
`timescale 1ns/1ns

// Axis stand-in: integrates the speed target, runs relative moves and makes the home switch.
module shs_motor_model #(
  parameter int SW_POS   = 100,
  parameter int MOVE_LAT = 3
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // Commands from the sequencer
  input  wire logic [16:0] SPEED_CMD,
  input  wire logic        DECEL_ACTIVE,
  input  wire logic        MOVE_START,
  input  wire logic [31:0] MOVE_DIST,
  // Bench position preset
  input  wire logic        PRESET_EN,
  input  wire logic [31:0] PRESET_VAL,
  // Feedback
  output logic      [31:0] POS_FB,
  output logic             MOVE_DONE,
  output logic             HOME_SW
);
  logic [2:0] cnt_q;
  logic       moving_q;

  assign HOME_SW = $signed(POS_FB) >= SW_POS;

  // The shaft is held while braking, so a short ramp never carries it back over the switch.
  // Move completion is a single-cycle pulse so a stale level cannot end the next move early.
  always_ff @(posedge REF_CLK) begin
    MOVE_DONE <= 1'b0;
    if (RESET) begin
      POS_FB   <= 32'h0000_0000;
      moving_q <= 1'b0;
      cnt_q    <= 3'h0;
    end else if (PRESET_EN) begin
      POS_FB <= PRESET_VAL;
    end else begin
      if (!DECEL_ACTIVE) begin
        POS_FB <= POS_FB + 32'($signed(SPEED_CMD));
      end
      if (MOVE_START) begin
        moving_q <= 1'b1;
        cnt_q    <= 3'h0;
      end else if (moving_q) begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'(MOVE_LAT)) begin
          POS_FB    <= POS_FB + MOVE_DIST;
          MOVE_DONE <= 1'b1;
          moving_q  <= 1'b0;
        end
      end
    end
  end
endmodule : shs_motor_model

// file: tb_top.sv
`timescale 1ns/1ns

module tb_top;
  logic        REF_CLK, RESET, CLK_EN, HSEL, HWRITE, SERVO_ON, POS_MODE, INTR_POS_BUSY;
  logic        MULTI_POS_BUSY, HOMING_TRIGGER_INPUT, FWD_LIMIT, PRESET_EN, HREADYOUT, HRESP;
  logic        HOME_SW, MOVE_DONE, DECEL_ACTIVE, MOVE_START, STOP_REQ, REF_LOCK, FILTER_BYPASS;
  logic        FWD_OT_FAULT, REV_OT_FAULT, HOMING_DONE, ELEC_HOMING_DONE, saw_rl, saw_fl, REV_LIMIT;
  logic [1:0]  HTRANS, STOP_METHOD;
  logic [15:0] DECEL_TIME_MS;
  logic [16:0] SPEED_CMD;
  logic [31:0] HADDR, HWDATA, PRESET_VAL, HRDATA, POS_FB, MOVE_DIST, ABS_POS, rd, off, abs0;
  int          n_errors, compares;

  shs_homing #(.CYC_PER_MS(4)) i_shs_homing (
    .REF_CLK(REF_CLK), .RESET(RESET), .CLK_EN(CLK_EN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SERVO_ON(SERVO_ON),
    .POS_MODE(POS_MODE), .INTR_POS_BUSY(INTR_POS_BUSY), .MULTI_POS_BUSY(MULTI_POS_BUSY),
    .HOMING_TRIGGER_INPUT(HOMING_TRIGGER_INPUT), .HOME_SW(HOME_SW), .Z_PULSE(1'b0),
    .FWD_LIMIT(FWD_LIMIT), .REV_LIMIT(REV_LIMIT), .POS_FB(POS_FB), .MOVE_DONE(MOVE_DONE),
    .SPEED_CMD(SPEED_CMD), .DECEL_ACTIVE(DECEL_ACTIVE), .DECEL_TIME_MS(DECEL_TIME_MS),
    .MOVE_START(MOVE_START), .MOVE_DIST(MOVE_DIST), .STOP_REQ(STOP_REQ),
    .STOP_METHOD(STOP_METHOD), .REF_LOCK(REF_LOCK), .FILTER_BYPASS(FILTER_BYPASS),
    .FWD_OT_FAULT(FWD_OT_FAULT), .REV_OT_FAULT(REV_OT_FAULT), .HOMING_DONE(HOMING_DONE),
    .ELEC_HOMING_DONE(ELEC_HOMING_DONE), .ABS_POS(ABS_POS));

  shs_motor_model i_shs_motor_model (
    .REF_CLK(REF_CLK), .RESET(RESET), .SPEED_CMD(SPEED_CMD), .DECEL_ACTIVE(DECEL_ACTIVE),
    .MOVE_START(MOVE_START), .MOVE_DIST(MOVE_DIST), .PRESET_EN(PRESET_EN),
    .PRESET_VAL(PRESET_VAL), .POS_FB(POS_FB), .MOVE_DONE(MOVE_DONE), .HOME_SW(HOME_SW));

  always #25 REF_CLK = ~REF_CLK;

  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : cyc

  task automatic print_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk

  // Single word transfer; the address phase is held until the slave shows ready.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h00_0000, a};
    do begin cyc(1); n++; end while (HREADYOUT !== 1'b1 && n < 50);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do begin cyc(1); n++; end while (HREADYOUT !== 1'b1 && n < 100);
    rd = HRDATA;
    if (n >= 100) begin
      $display("ERROR bus ready expected 1 seen %b", HREADYOUT);
      n_errors++;
      print_verdict();
    end
  endtask : ahb

  // Kinds: 0 lock level, 1 move start pulse, 2 stop pulse.
  task automatic wait_sig(input int k, input logic v);
    int   n;
    logic s;
    n = 0;
    do begin
      cyc(1);
      n++;
      if (SPEED_CMD === 17'h1_FFFF) saw_rl = 1'b1;
      if (SPEED_CMD === 17'h0_0001) saw_fl = 1'b1;
      case (k)
        0: s = REF_LOCK;
        1: s = MOVE_START;
        default: s = STOP_REQ;
      endcase
    end while (s !== v && n < 600);
    if (s !== v) begin
      $display("ERROR wait kind %0d expected %b seen %b", k, v, s);
      n_errors++;
      print_verdict();
    end
  endtask : wait_sig

  task automatic cfg(input logic [3:0] axis, input logic [3:0] trg, input logic [1:0] limr);
    ahb(1'b1, shs_pkg::OFS_CTRL, {10'h000, 2'h2, 2'h0, limr, 8'h00, trg, axis});
  endtask : cfg

  task automatic preset(input logic [31:0] v);
    PRESET_EN <= 1'b1;
    PRESET_VAL <= v;
    cyc(1);
    PRESET_EN <= 1'b0;
  endtask : preset

  task automatic t_regs;
    ahb(1'b1, shs_pkg::OFS_HI_SPD, 32'h0000_0004);
    ahb(1'b0, shs_pkg::OFS_HI_SPD, 32'h0000_0000);
    chk("high speed", 32'h0000_0004, rd);
    ahb(1'b1, shs_pkg::OFS_LO_SPD, 32'h0000_0001);
    ahb(1'b1, shs_pkg::OFS_DEC_MS, 32'h0000_0001);
    ahb(1'b1, shs_pkg::OFS_OFFSET, off);
    ahb(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    cfg(4'h0, 4'h1, 2'h0);
    ahb(1'b0, shs_pkg::OFS_CTRL, 32'h0000_0000);
    chk("control", 32'h0020_0010, rd);
    chk("bus response", 32'h0, 32'(HRESP));
    chk("decel time", 32'h1, 32'(DECEL_TIME_MS));
    // A trigger pulse that falls inside a frozen stretch is lost.
    CLK_EN <= 1'b0;
    HOMING_TRIGGER_INPUT <= 1'b1;
    cyc(2);
    chk("frozen ready", 32'h0, 32'(HREADYOUT));
    chk("frozen start", 32'h0, 32'(REF_LOCK));
    CLK_EN <= 1'b1;
    HOMING_TRIGGER_INPUT <= 1'b0;
    cyc(2);
    chk("no late start", 32'h0, 32'(REF_LOCK));
    $display("test registers finished");
  endtask : t_regs

  task automatic t_home(input logic [31:0] start, input logic [16:0] first);
    preset(start);
    saw_rl = 1'b0;
    saw_fl = 1'b0;
    HOMING_TRIGGER_INPUT <= 1'b1;
    wait_sig(0, 1'b1);
    HOMING_TRIGGER_INPUT <= 1'b0;
    chk("first speed", 32'(first), 32'(SPEED_CMD));
    chk("filter bypass", 32'h1, 32'(FILTER_BYPASS));
    chk("done cleared", 32'h0, 32'(HOMING_DONE));
    wait_sig(1, 1'b1);
    chk("lock in move", 32'h1, 32'(REF_LOCK));
    chk("offset move", off, MOVE_DIST);
    chk("stop speed", 32'h0, 32'(SPEED_CMD));
    chk("slow reverse", 32'h1, 32'(saw_rl));
    chk("slow forward", 32'h1, 32'(saw_fl));
    wait_sig(0, 1'b0);
    chk("homing done", 32'h1, 32'(HOMING_DONE));
    chk("elec done", 32'h0, 32'(ELEC_HOMING_DONE));
    cyc(1);
    chk("abs position", off, ABS_POS);
    $display("test homing from %0d finished", start);
  endtask : t_home

  task automatic t_elec;
    off = 32'h0000_0032;
    ahb(1'b1, shs_pkg::OFS_OFFSET, off);
    cfg(4'h0, 4'h2, 2'h0);
    HOMING_TRIGGER_INPUT <= 1'b1;
    wait_sig(1, 1'b1);
    HOMING_TRIGGER_INPUT <= 1'b0;
    chk("elec distance", off - 32'h0000_0025, MOVE_DIST);
    chk("homing flag cleared", 32'h0, 32'(HOMING_DONE));
    wait_sig(0, 1'b0);
    chk("elec done", 32'h1, 32'(ELEC_HOMING_DONE));
    cyc(1);
    chk("abs position", off, ABS_POS);
    $display("test electrical homing finished");
  endtask : t_elec

  task automatic t_limit_rev;
    cfg(4'h0, 4'h1, 2'h2);
    preset(32'h0000_0000);
    saw_fl = 1'b0;
    HOMING_TRIGGER_INPUT <= 1'b1;
    wait_sig(0, 1'b1);
    HOMING_TRIGGER_INPUT <= 1'b0;
    FWD_LIMIT <= 1'b1;
    cyc(1);
    FWD_LIMIT <= 1'b0;
    cyc(1);
    chk("reverse high", 32'h0001_FFFC, 32'(SPEED_CMD));
    chk("fwd fault", 32'h1, 32'(FWD_OT_FAULT));
    chk("still homing", 32'h1, 32'(REF_LOCK));
    preset(32'h0000_00C8);
    wait_sig(1, 1'b1);
    chk("slow forward", 32'h1, 32'(saw_fl));
    chk("offset move", off, MOVE_DIST);
    wait_sig(0, 1'b0);
    chk("homing done", 32'h1, 32'(HOMING_DONE));
    $display("test limit reversal finished");
  endtask : t_limit_rev

  task automatic t_blocked;
    for (int k = 0; k < 6; k++) begin
      cfg((k == 2) ? 4'h5 : 4'h0, (k == 4) ? 4'h0 : 4'h1, 2'h0);
      INTR_POS_BUSY <= (k == 0);
      MULTI_POS_BUSY <= (k == 1);
      POS_MODE <= (k != 3);
      SERVO_ON <= (k != 5);
      HOMING_TRIGGER_INPUT <= 1'b1;
      cyc(4);
      chk("blocked start", 32'h0, 32'(REF_LOCK));
      HOMING_TRIGGER_INPUT <= 1'b0;
      cyc(1);
    end
    INTR_POS_BUSY <= 1'b0;
    MULTI_POS_BUSY <= 1'b0;
    POS_MODE <= 1'b1;
    $display("test blocked starts finished");
  endtask : t_blocked

  // A search halted at the limit ahead in the fast phase leaves the next start in reverse at high speed.
  task automatic t_son;
    for (int i = 0; i < 2; i++) begin
      cfg(4'h0, (i == 0) ? 4'h3 : 4'h4, 2'h0);
      preset(32'h0000_0000);
      SERVO_ON <= 1'b0;
      cyc(2);
      SERVO_ON <= 1'b1;
      wait_sig(0, 1'b1);
      chk("servo start speed", (i == 0) ? 32'h4 : 32'h0001_FFFC, 32'(SPEED_CMD));
      FWD_LIMIT <= (i == 0);
      REV_LIMIT <= (i == 1);
      wait_sig(2, 1'b1);
      FWD_LIMIT <= 1'b0;
      REV_LIMIT <= 1'b0;
      chk("fwd fault", 32'(i == 0), 32'(FWD_OT_FAULT));
      chk("rev fault", 32'(i == 1), 32'(REV_OT_FAULT));
      chk("stop method", 32'h2, 32'(STOP_METHOD));
      cyc(1);
      chk("halted", 32'h0, 32'(REF_LOCK));
    end
    cfg(4'h0, 4'h5, 2'h0);
    SERVO_ON <= 1'b0;
    cyc(2);
    abs0 = ABS_POS;
    SERVO_ON <= 1'b1;
    wait_sig(1, 1'b1);
    chk("elec distance", off - abs0, MOVE_DIST);
    wait_sig(0, 1'b0);
    chk("elec done", 32'h1, 32'(ELEC_HOMING_DONE));
    cyc(1);
    chk("abs position", off, ABS_POS);
    $display("test servo-on starts finished");
  endtask : t_son

  initial begin
    REF_CLK = 1'b0;
    RESET = 1'b1;
    {HSEL, HWRITE, INTR_POS_BUSY, MULTI_POS_BUSY, HOMING_TRIGGER_INPUT} = 5'h00;
    {FWD_LIMIT, REV_LIMIT, PRESET_EN, saw_rl, saw_fl} = 5'h00;
    CLK_EN = 1'b1;
    SERVO_ON = 1'b1;
    POS_MODE = 1'b1;
    HTRANS = 2'h0;
    HADDR = 32'h0000_0000;
    HWDATA = 32'h0000_0000;
    PRESET_VAL = 32'h0000_0000;
    off = 32'h0000_0025;
    n_errors = 0;
    compares = 0;
    cyc(6);
    RESET <= 1'b0;
    cyc(1);
    t_regs();
    t_home(32'h0000_0000, 17'h0_0004);
    t_home(32'h0000_0096, 17'h1_FFFF);
    t_elec();
    t_limit_rev();
    t_blocked();
    t_son();
    print_verdict();
  end
endmodule : tb_top
